// ### radio_ctl_regs.svh
// register offsets, field positions, reset values and timing constants of the radio control bank
`ifndef RADIO_CTL_REGS_SVH
`define RADIO_CTL_REGS_SVH

`define OFF_WAKE_STATUS 6'h1d
`define OFF_ANALOG_CONTROL 6'h20
`define OFF_CHANNEL_SELECT 6'h21
`define OFF_SIGNAL_STRENGTH 6'h22
`define OFF_TX_POWER 6'h23
`define OFF_CRYSTAL_TRIM 6'h24
`define OFF_VCO_SLOPE 6'h26
`define OFF_GAIN_LOCK 6'h2e
`define OFF_CARRIER_OVERRIDE 6'h2f
`define OFF_CLOCK_OVERRIDE 6'h32
`define OFF_CLOCK_GATE_ENABLE 6'h33
`define OFF_SYNTH_LOCK_DELAY 6'h38
`define OFF_SERIAL_BASE 4'hf

`define RST_BYTE 8'h00
`define RST_LOCK_DELAY 8'h64

`define ANA_GAIN_WR_EN 6
`define ANA_ID_RD_EN 5
`define ANA_DRIVE_EN 2
`define ANA_POLARITY 1
`define ANA_SOFT_RST 0
`define ANA_WMASK 8'h67
`define PWR_WMASK 8'h07
`define XTAL_WMASK 8'h7f
`define VCO_WMASK 8'hc0
`define FLAG_WMASK 8'h80
`define WAKE_SPARE 7'h00
`define RSSI_SPARE 2'b00
`define CHAN_SRC_BIT 7
`define RSSI_VALID_BIT 5
`define TOP_BIT 7
`define XTAL_CLKOFF_BIT 6

`define LOCK_STEP_NS 2000
`define CLK_PERIOD_NS 20
`define LOCK_STEP_CYC ((`LOCK_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### radio_ctl_pkg.sv
// types shared by the radio control bank
package radio_ctl_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] reg_addr_t;
    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_WAIT,
        LOCK_DONE
    } lock_state_t;
endpackage

// ### wake_detect.sv
// wake-up event generator from the power-down pin
`timescale 1ns/1ps
`include "radio_ctl_regs.svh"
module wake_detect
    import radio_ctl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // power-down pin, low = suspend
    input wire logic power_down_pin,
    // device ready for host transfers
    input wire logic host_ready,
    // one-cycle wake event
    output logic wake_event
);
    logic armed_q;
    logic armed_d;
    wire fire = armed_q && power_down_pin && host_ready;

    // ----------------------------------------
    // arm on suspend, fire once when released and ready
    // ----------------------------------------
    assign armed_d = !power_down_pin ? 1'b1 : (fire ? 1'b0 : armed_q);
    assign wake_event = fire;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= armed_d;
        end
    end
endmodule // wake_detect

// ### lock_timer.sv
// synthesizer lock delay timer, count times 2 us
`timescale 1ns/1ps
`include "radio_ctl_regs.svh"
module lock_timer
    import radio_ctl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // start request and programmed count
    input wire logic start,
    input wire logic [7:0] count,
    // lock wait finished
    output logic locked
);
    localparam int STEP = `LOCK_STEP_CYC;
    lock_state_t state_q;
    logic [6:0] sub_q;
    logic [7:0] steps_q;
    wire step_end = (sub_q == 7'(STEP - 1));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= LOCK_IDLE;
            sub_q <= 7'h00;
            steps_q <= 8'h00;
        end else begin
            case (state_q)
                LOCK_IDLE, LOCK_DONE: begin
                    if (start) begin
                        state_q <= (count == 8'h00) ? LOCK_DONE : LOCK_WAIT;
                        steps_q <= count;
                        sub_q <= 7'h00;
                    end
                end
                LOCK_WAIT: begin
                    sub_q <= step_end ? 7'h00 : sub_q + 7'h01;
                    if (step_end) begin
                        steps_q <= steps_q - 8'h01;
                        if (steps_q == 8'h01) begin
                            state_q <= LOCK_DONE;
                        end
                    end
                end
                default: state_q <= LOCK_IDLE;
            endcase
        end
    end
    assign locked = (state_q == LOCK_DONE);
endmodule // lock_timer

// ### radio_control_register_bank.sv
// configuration and status register bank of the 2.4 GHz radio
//
// Functional notes
// - wake status bit sets on wake-up, clears on read; other bits read zero.
// - wake-up fires once power-down releases and host transfers are possible.
// - serial number reads only while id read enable is set; read-only.
// - amplifier pin driven only while its drive enable bit is one.
// - polarity bit one makes amplifier pin active low, zero active high.
// - source bit selects A/N counters or the channel field for synthesizer.
// - channel n maps to 2401+n MHz, 1 MHz spacing.
// - signal strength register is read-only: 5-bit value plus valid flag.
// - 3-bit transmit gain level, higher code gives more power.
// - clock-off bit stops the buffered clock output; on after reset.
// - 6-bit crystal trim sets oscillator load capacitance.
// - oscillator slope field is write-only; reads return zero here.
// - gain lock bit freezes amplifier at maximum gain.
// - carrier override bit forces carrier detect indication.
// - lock delay waits count times 2 us; count resets to 64 hex.
`timescale 1ns/1ps
`include "radio_ctl_regs.svh"
module radio_control_register_bank
    import radio_ctl_pkg::*;
#(
    parameter logic [31:0] SERIAL_ID = 32'h1234_5678 // arbitrary value
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // power management
    input wire logic power_down_pin,
    input wire logic host_ready,
    // receiver status
    input wire logic [4:0] rssi_level,
    input wire logic rssi_valid,
    input wire logic carrier_detect_raw,
    // synthesizer lock request
    input wire logic synth_start,
    // external amplifier pin
    output logic ext_amp_control_pin_o,
    output logic ext_amp_control_pin_oe_n,
    input wire logic tx_active,
    // buffered clock output
    input wire logic ref_clk_13m,
    output logic buffered_clock_out_pin,
    // analog controls
    output logic synth_use_counters,
    output logic [6:0] channel_num,
    output logic [2:0] tx_gain_level,
    output logic [5:0] crystal_load,
    output logic [1:0] osc_slope_adjust,
    output logic gain_locked,
    output logic carrier_detect,
    output logic [7:0] clock_override,
    output logic [7:0] clock_gate_enable,
    output logic synth_locked,
    output logic id_power_on
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    byte_t ana_q;
    byte_t chan_q;
    byte_t pwr_q;
    byte_t xtal_q;
    byte_t vco_q;
    byte_t agc_q;
    byte_t cd_q;
    byte_t clko_q;
    byte_t clke_q;
    byte_t lock_q;
    logic wake_q;
    byte_t rdata_q;
    logic wake_event;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire hit_wake = (reg_addr == `OFF_WAKE_STATUS);
    wire hit_ana = (reg_addr == `OFF_ANALOG_CONTROL);
    wire hit_chan = (reg_addr == `OFF_CHANNEL_SELECT);
    wire hit_rssi = (reg_addr == `OFF_SIGNAL_STRENGTH);
    wire hit_pwr = (reg_addr == `OFF_TX_POWER);
    wire hit_xtal = (reg_addr == `OFF_CRYSTAL_TRIM);
    wire hit_vco = (reg_addr == `OFF_VCO_SLOPE);
    wire hit_agc = (reg_addr == `OFF_GAIN_LOCK);
    wire hit_cd = (reg_addr == `OFF_CARRIER_OVERRIDE);
    wire hit_clko = (reg_addr == `OFF_CLOCK_OVERRIDE);
    wire hit_clke = (reg_addr == `OFF_CLOCK_GATE_ENABLE);
    wire hit_lock = (reg_addr == `OFF_SYNTH_LOCK_DELAY);
    wire hit_serial = (reg_addr[5:2] == `OFF_SERIAL_BASE);

    // ----------------------------------------
    // write and read strobes
    // ----------------------------------------
    wire gain_wr_ok = ana_q[`ANA_GAIN_WR_EN];
    wire id_en = ana_q[`ANA_ID_RD_EN];
    wire wr_ana = reg_wr && hit_ana;
    wire soft_rst = wr_ana && reg_wdata[`ANA_SOFT_RST];
    wire wr_chan = reg_wr && hit_chan;
    wire wr_pwr = reg_wr && hit_pwr;
    wire wr_xtal = reg_wr && hit_xtal;
    wire wr_vco = reg_wr && hit_vco;
    wire wr_agc = reg_wr && hit_agc && gain_wr_ok;
    wire wr_cd = reg_wr && hit_cd && gain_wr_ok;
    wire wr_clko = reg_wr && hit_clko;
    wire wr_clke = reg_wr && hit_clke;
    wire wr_lock = reg_wr && hit_lock;
    wire rd_wake = reg_rd && hit_wake;

    // ----------------------------------------
    // write data masks
    // ----------------------------------------
    wire [7:0] ana_wdata = reg_wdata & `ANA_WMASK;
    wire [7:0] pwr_wdata = reg_wdata & `PWR_WMASK;
    wire [7:0] xtal_wdata = reg_wdata & `XTAL_WMASK;
    wire [7:0] vco_wdata = reg_wdata & `VCO_WMASK;
    wire [7:0] flag_wdata = reg_wdata & `FLAG_WMASK;

    // ----------------------------------------
    // read data selection
    // ----------------------------------------
    wire [7:0] serial_byte = SERIAL_ID[{reg_addr[1:0], 3'b000} +: 8];
    wire [7:0] rd_wake_val = {`WAKE_SPARE, wake_q};
    wire [7:0] rd_rssi_val = {`RSSI_SPARE, rssi_valid, rssi_level};
    wire [7:0] rd_vco_val = `RST_BYTE;
    wire [7:0] rd_serial_val = id_en ? serial_byte : `RST_BYTE;
    wire [7:0] rd_mux =
        hit_wake ? rd_wake_val :
        hit_ana ? ana_q :
        hit_chan ? chan_q :
        hit_rssi ? rd_rssi_val :
        hit_pwr ? pwr_q :
        hit_xtal ? xtal_q :
        hit_vco ? rd_vco_val :
        hit_agc ? agc_q :
        hit_cd ? cd_q :
        hit_clko ? clko_q :
        hit_clke ? clke_q :
        hit_lock ? lock_q :
        hit_serial ? rd_serial_val :
        `RST_BYTE;

    // ----------------------------------------
    // wake detection
    // ----------------------------------------
    wake_detect u_wake (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .power_down_pin(power_down_pin),
        .host_ready(host_ready),
        .wake_event(wake_event)
    );

    // ----------------------------------------
    // wake status flag, set wins over the clearing read
    // ----------------------------------------
    wire wake_clr = rd_wake || soft_rst;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wake_q <= 1'b0;
        end else if (wake_event) begin
            wake_q <= 1'b1;
        end else if (wake_clr) begin
            wake_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    // analog control
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ana_q <= `RST_BYTE;
        end else if (soft_rst) begin
            ana_q <= `RST_BYTE;
        end else if (wr_ana) begin
            ana_q <= ana_wdata;
        end
    end

    // channel and source select
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chan_q <= `RST_BYTE;
        end else if (soft_rst) begin
            chan_q <= `RST_BYTE;
        end else if (wr_chan) begin
            chan_q <= reg_wdata;
        end
    end

    // transmit gain level
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pwr_q <= `RST_BYTE;
        end else if (soft_rst) begin
            pwr_q <= `RST_BYTE;
        end else if (wr_pwr) begin
            pwr_q <= pwr_wdata;
        end
    end

    // crystal trim and clock-off
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            xtal_q <= `RST_BYTE;
        end else if (soft_rst) begin
            xtal_q <= `RST_BYTE;
        end else if (wr_xtal) begin
            xtal_q <= xtal_wdata;
        end
    end

    // oscillator slope
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            vco_q <= `RST_BYTE;
        end else if (soft_rst) begin
            vco_q <= `RST_BYTE;
        end else if (wr_vco) begin
            vco_q <= vco_wdata;
        end
    end

    // gain lock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            agc_q <= `RST_BYTE;
        end else if (soft_rst) begin
            agc_q <= `RST_BYTE;
        end else if (wr_agc) begin
            agc_q <= flag_wdata;
        end
    end

    // carrier override
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cd_q <= `RST_BYTE;
        end else if (soft_rst) begin
            cd_q <= `RST_BYTE;
        end else if (wr_cd) begin
            cd_q <= flag_wdata;
        end
    end

    // clock override
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clko_q <= `RST_BYTE;
        end else if (soft_rst) begin
            clko_q <= `RST_BYTE;
        end else if (wr_clko) begin
            clko_q <= reg_wdata;
        end
    end

    // clock gate enable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clke_q <= `RST_BYTE;
        end else if (soft_rst) begin
            clke_q <= `RST_BYTE;
        end else if (wr_clke) begin
            clke_q <= reg_wdata;
        end
    end

    // synthesizer lock count
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lock_q <= `RST_LOCK_DELAY;
        end else if (soft_rst) begin
            lock_q <= `RST_LOCK_DELAY;
        end else if (wr_lock) begin
            lock_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `RST_BYTE;
        end else begin
            rdata_q <= reg_rd ? rd_mux : `RST_BYTE;
        end
    end
    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // synthesizer lock delay
    // ----------------------------------------
    lock_timer u_lock (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(synth_start),
        .count(lock_q),
        .locked(synth_locked)
    );

    // ----------------------------------------
    // analog control outputs
    // ----------------------------------------
    wire amp_drive_en = ana_q[`ANA_DRIVE_EN];
    wire amp_invert = ana_q[`ANA_POLARITY];
    wire clk_out_off = xtal_q[`XTAL_CLKOFF_BIT];
    assign ext_amp_control_pin_oe_n = !amp_drive_en;
    assign ext_amp_control_pin_o = tx_active ^ amp_invert;
    assign buffered_clock_out_pin = ref_clk_13m && !clk_out_off && power_down_pin;

    // ----------------------------------------
    // synthesizer, gain and trim controls
    // ----------------------------------------
    assign synth_use_counters = chan_q[`CHAN_SRC_BIT];
    assign channel_num = chan_q[6:0];
    assign tx_gain_level = pwr_q[2:0];
    assign crystal_load = xtal_q[5:0];
    assign osc_slope_adjust = vco_q[7:6];
    assign gain_locked = agc_q[`TOP_BIT];
    assign carrier_detect = carrier_detect_raw || cd_q[`TOP_BIT];

    // ----------------------------------------
    // clock overrides and id power
    // ----------------------------------------
    assign clock_override = clko_q;
    assign clock_gate_enable = clke_q;
    assign id_power_on = id_en;
endmodule // radio_control_register_bank

// ### radio_ctl_properties.sv
// port checker for the radio control bank
`timescale 1ns/1ps
module radio_ctl_checker (
    // clock and register port
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and status
    input wire logic [4:0] rssi_level,
    input wire logic rssi_valid,
    input wire logic carrier_detect_raw,
    input wire logic carrier_detect,
    input wire logic synth_start,
    input wire logic synth_locked,
    input wire logic tx_active,
    input wire logic ext_amp_control_pin_o,
    input wire logic ext_amp_control_pin_oe_n,
    input wire logic buffered_clock_out_pin,
    input wire logic [6:0] channel_num
);
    logic [15:0] cyc_q;
    wire wr20 = reg_wr && reg_addr == 6'h20;
    // cycles since the last lock request
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) cyc_q <= 16'h0000;
        else cyc_q <= synth_start ? 16'h0001 : cyc_q + 16'h0001;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_WAKE_RSV: assert property (reg_rd && reg_addr == 6'h1d |=> reg_rdata[7:1] == 7'h00)
        else $error("wake status spare bits set");
    AST_RSSI_RO: assert property (reg_rd && reg_addr == 6'h22
        |=> reg_rdata[5:0] == {$past(rssi_valid), $past(rssi_level)}) else $error("signal strength wrong");
    AST_AMP_OE: assert property (wr20 && !reg_wdata[0]
        |=> ext_amp_control_pin_oe_n == !$past(reg_wdata[2])) else $error("amp pin enable wrong");
    AST_AMP_POL: assert property (wr20 && !reg_wdata[0] && reg_wdata[2]
        |=> ext_amp_control_pin_o == (tx_active ^ $past(reg_wdata[1]))) else $error("amp pin level wrong");
    AST_CHAN: assert property (reg_wr && reg_addr == 6'h21 |=> channel_num == $past(reg_wdata[6:0]))
        else $error("channel not taken");
    AST_CLK_OFF: assert property (reg_wr && reg_addr == 6'h24 && reg_wdata[6] |=> !buffered_clock_out_pin)
        else $error("clock output not stopped");
    AST_CARRIER: assert property (carrier_detect_raw |-> carrier_detect)
        else $error("carrier detect lost");
    AST_LOCK_TIME: assert property ($rose(synth_locked) |-> cyc_q % 16'h0064 inside {16'h0000, 16'h0001})
        else $error("lock delay not a whole step count");
    AST_SOFT_RST: assert property (wr20 && reg_wdata[0] |=> channel_num == 7'h00 && ext_amp_control_pin_oe_n)
        else $error("soft reset incomplete");
endmodule // radio_ctl_checker

bind radio_control_register_bank radio_ctl_checker u_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rssi_level, .rssi_valid, .carrier_detect_raw, .carrier_detect, .synth_start,
    .synth_locked, .tx_active, .ext_amp_control_pin_o, .ext_amp_control_pin_oe_n, .buffered_clock_out_pin,
    .channel_num);

// ### radio_host_model.sv
// host model driving the register port
`timescale 1ns/1ps
module radio_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // bring-up after the soft reset
    task automatic init();
        wr(6'h32, 8'h41);
        wr(6'h33, 8'h41);
        wr(6'h26, 8'hc0);
        wr(6'h20, 8'h40);
        wr(6'h2e, 8'h80);
        wr(6'h2f, 8'h80);
        wr(6'h21, 8'h05);
        wr(6'h24, 8'h40);
    endtask
endmodule // radio_host_model

// ### radio_control_register_bank_tb.sv
// self-checking bench for the radio control bank
`timescale 1ns/1ps
module radio_control_register_bank_tb;
    localparam logic [31:0] SID = 32'h5a3c_9617; // arbitrary value
    logic clk_sys, rstn, power_down_pin, host_ready, rssi_valid, carrier_detect_raw, synth_start, tx_active;
    logic ref_clk_13m, reg_wr, reg_rd, ext_amp_control_pin_o, ext_amp_control_pin_oe_n, buffered_clock_out_pin;
    logic synth_use_counters, gain_locked, carrier_detect, synth_locked, id_power_on;
    logic [4:0] rssi_level;
    logic [5:0] reg_addr, crystal_load;
    logic [7:0] reg_wdata, reg_rdata, d, clock_override, clock_gate_enable;
    logic [6:0] channel_num;
    logic [2:0] tx_gain_level;
    logic [1:0] osc_slope_adjust;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    logic [23:0] t[$];
    logic [5:0] ra[$];
    radio_control_register_bank #(.SERIAL_ID(SID)) DUT (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .power_down_pin, .host_ready, .rssi_level, .rssi_valid, .carrier_detect_raw, .synth_start,
        .ext_amp_control_pin_o, .ext_amp_control_pin_oe_n, .tx_active, .ref_clk_13m, .buffered_clock_out_pin,
        .synth_use_counters, .channel_num, .tx_gain_level, .crystal_load, .osc_slope_adjust, .gain_locked,
        .carrier_detect, .clock_override, .clock_gate_enable, .synth_locked, .id_power_on);
    radio_host_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        ref_clk_13m = 1'b0;
        forever #38.462 ref_clk_13m = ~ref_clk_13m;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200us;
        error_cnt++;
        complete_run();
    end
    initial begin
        {rstn, power_down_pin, host_ready, rssi_valid, carrier_detect_raw, synth_start, tx_active} = 7'b0100000;
        rssi_level = 5'h00;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        host_ready <= 1'b1;
        ra = '{6'h00, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h26, 6'h2e, 6'h2f, 6'h32, 6'h33, 6'h38, 6'h3c};
        foreach (ra[i]) begin
            host.rd(ra[i], d);
            chk(d, ra[i] == 6'h38 ? 8'h64 : 8'h00);
        end
        chk({ext_amp_control_pin_oe_n, buffered_clock_out_pin}, {1'b1, ref_clk_13m});
        host.rd(6'h1d, d);
        chk(d, 8'h01);
        host.rd(6'h1d, d);
        chk(d, 8'h00);
        @(posedge clk_sys);
        power_down_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        power_down_pin <= 1'b1;
        host.rd(6'h1d, d);
        chk(d, 8'h01);
        t = '{24'h21ff_ff, 24'h23ff_07, 24'h24bf_3f, 24'h26ff_00, 24'h2eff_00, 24'h38ff_ff, 24'h3cff_00, 24'h3fff_00};
        foreach (t[i]) host.wr(t[i][21:16], t[i][15:8]);
        foreach (t[i]) begin
            host.rd(t[i][21:16], d);
            chk(d, t[i][7:0]);
        end
        chk({synth_use_counters, channel_num}, 8'hff);
        chk({tx_gain_level, crystal_load}, 9'h1ff);
        chk({osc_slope_adjust, buffered_clock_out_pin, gain_locked}, {2'b11, ref_clk_13m, 1'b0});
        @(posedge clk_sys);
        rssi_level <= 5'h15;
        rssi_valid <= 1'b1;
        host.rd(6'h22, d);
        chk(d, 8'h35);
        host.wr(6'h20, 8'h01);
        host.rd(6'h21, d);
        chk(d, 8'h00);
        host.rd(6'h38, d);
        chk(d, 8'h64);
        host.wr(6'h2f, 8'h80);
        chk(carrier_detect, 1'b0);
        host.init();
        chk({gain_locked, carrier_detect, osc_slope_adjust, buffered_clock_out_pin}, 5'h1e);
        chk({clock_override, clock_gate_enable}, 16'h4141);
        host.wr(6'h20, 8'h60);
        for (int i = 0; i < 4; i++) begin
            host.rd(6'h3c + 6'(i), d);
            chk(d, SID[8*i +: 8]);
        end
        chk(id_power_on, 1'b1);
        host.wr(6'h20, 8'h40);
        @(posedge clk_sys);
        tx_active <= 1'b1;
        host.wr(6'h20, 8'h44);
        chk({ext_amp_control_pin_oe_n, ext_amp_control_pin_o}, 2'b01);
        host.wr(6'h20, 8'h46);
        chk({ext_amp_control_pin_oe_n, ext_amp_control_pin_o}, 2'b00);
        host.wr(6'h20, 8'h44);
        chk({ext_amp_control_pin_oe_n, ext_amp_control_pin_o}, 2'b01);
        host.wr(6'h20, 8'h40);
        chk(ext_amp_control_pin_oe_n, 1'b1);
        host.wr(6'h38, 8'h02);
        @(posedge clk_sys);
        synth_start <= 1'b1;
        carrier_detect_raw <= 1'b1;
        @(posedge clk_sys);
        synth_start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (synth_locked !== 1'b1 && n < 1000);
        chk(n >= 200 && n <= 201, 1'b1);
        complete_run();
    end
endmodule // radio_control_register_bank_tb
